// ### hdl/crossbar_map.svh
/*
 Constants of the crossbar route-enable registers: addresses, field
 positions, reset values and the signal numbering seen by the decoder.
 Assumes an 8-bit special-function address space and 8-bit data.
*/
`ifndef CROSSBAR_MAP_SVH
`define CROSSBAR_MAP_SVH

`define XBR_ADDR_A 8'hE1
`define XBR_ADDR_B 8'hE2
`define XBR_RST 8'h00

`define A_CMP0_BIT 7
`define A_ECLK_BIT 6
`define A_CC_HI 5
`define A_CC_LO 3
`define A_UART_BIT 2
`define A_SPI_BIT 1
`define A_SMB_BIT 0
`define CC_MAX 3'h5
`define CC_LINES 5

`define B_SYSCK_BIT 7
`define B_TMR2_CAPTURE_IN_BIT 6
`define B_T2_BIT 5
`define B_EXT_IRQ_ONE_IN_BIT 4
`define B_T1_BIT 3
`define B_EXT_IRQ_ZERO_IN_BIT 2
`define B_T0_BIT 1
`define B_CMP1_BIT 0

`define NSIG 23
`define NPIN 24
`define SEL_W 5
`define SIG_SMB 0
`define SIG_SPI 2
`define SIG_UART 6
`define SIG_CC 8
`define SIG_ECI 13
`define SIG_CP0 14
`define SIG_CP1 15
`define SIG_T0 16
`define SIG_EXT_IRQ_ZERO_IN 17
`define SIG_T1 18
`define SIG_EXT_IRQ_ONE_IN 19
`define SIG_T2 20
`define SIG_TMR2_CAPTURE_IN 21
`define SIG_SYSCK 22

`endif

// ### hdl/crossbar_pkg.sv
/*
 Types shared by the crossbar route-enable block and its decoder.
 Assumes crossbar_map.svh is on the include path.
*/
`include "crossbar_map.svh"
package crossbar_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;
	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
	} sfr_rsp_t;
	typedef struct packed {
		logic cmp0;
		logic eclk;
		logic [2:0] cc_cnt;
		logic uart;
		logic spi;
		logic smb;
		logic sysck;
		logic tmr2_capture_in;
		logic t2;
		logic ext_irq_one_in;
		logic t1;
		logic ext_irq_zero_in;
		logic t0;
		logic cmp1;
	} route_t;
	typedef logic [`NSIG-1:0] sig_vec_t;
	typedef logic [`NPIN-1:0][`SEL_W-1:0] pin_sel_t;

	// Pin slot of a signal: number of enabled signals ahead of it
	function automatic logic [`SEL_W-1:0] ones_below(sig_vec_t v, int idx);
		logic [`SEL_W-1:0] n;
		n = '0;
		for (int k = 0; k < `NSIG; k++) begin
			if (k < idx && v[k]) begin
				n = n + 5'h01;
			end
		end
		return n;
	endfunction
endpackage

// ### hdl/sfr_route_reg.sv
/*
 One 8-bit read/write special-function register at a fixed address.
 Assumes write strobes are single-cycle and synchronous to the clock.
*/
`timescale 1ns/1ps
`include "crossbar_map.svh"
module sfr_route_reg import crossbar_pkg::*; #(
	parameter logic [7:0] ADDR = 8'h00
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire sfr_req_t i_req,
	output logic [7:0] o_q,
	output logic o_hit
);
	logic [7:0] q_q;
	logic [7:0] q_d;
	wire logic wr_hit = i_req.wr && (i_req.addr == ADDR);

	assign o_hit = i_req.addr == ADDR;
	assign q_d = wr_hit ? i_req.wdata : q_q;
	assign o_q = q_q;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q_q <= `XBR_RST;
		end else begin
			q_q <= q_d;
		end
	end
endmodule

// ### hdl/slot_decoder.sv
/*
 Priority slot filler: enabled signals take pins in signal order, lowest pin first.
 Assumes enables are already gated by the global crossbar enable.
*/
`timescale 1ns/1ps
`include "crossbar_map.svh"
module slot_decoder import crossbar_pkg::*; (
	input wire sig_vec_t i_en,
	output pin_sel_t o_sel,
	output logic [`NPIN-1:0] o_func
);
	always_comb begin
		o_sel = '0;
		o_func = '0;
		for (int s = 0; s < `NSIG; s++) begin
			if (i_en[s]) begin
				o_sel[ones_below(i_en, s)] = `SEL_W'(s + 1);
			end
		end
		for (int p = 0; p < `NPIN; p++) begin
			o_func[p] = o_sel[p] != '0;
		end
	end
endmodule

// ### hdl/crossbar_route_enable_regs.sv
/*
 Crossbar route-enable registers with their priority pin decoder.
 Assumes the special-function bus is synchronous, and that the global
 crossbar enable comes from a register held elsewhere.
*/
// What this block does
// - Software picks, through the crossbar registers, which peripheral signals reach pins by fixed priority.
// - Bit 7 of route register A routes the comparator-0 output to a pin when set.
// - Bit 6 of route register A routes the counter-array external clock input when set.
// - Bits 5..3 of route register A route capture/compare lines 0..N-1, zero for none, 6 and 7 reserved.
// - Bit 2 of route register A routes UART receive and transmit together.
// - Bit 1 of route register A routes the four SPI signals together.
// - Bit 0 of route register A places SMBus data and clock on port 0 pins 0 and 1.
// - Bit 7 of route register B routes the system clock out to a pin.
// - Bit 6 of route register B routes the timer-2 capture/reload input.
// - Bits 5..1 of route register B route timer-2, irq-1, timer-1, irq-0 and timer-0 inputs.
// - Bit 0 of route register B routes the comparator-1 output.
// - Route register A resets to zero and is read/write at address E1.
// - Route register B resets to zero and is read/write at address E2.
// - Without the global crossbar enable every pin stays a plain port input.
// - Pins fill from the lowest bit of port 0 upward, enabled signals in priority order.
`timescale 1ns/1ps
`include "crossbar_map.svh"
module crossbar_route_enable_regs import crossbar_pkg::*; (
	input wire logic I_REF_CLK,
	input wire logic I_RST_B,
	input wire sfr_req_t I_SFR_REQ,
	input wire logic I_XBAR_EN,
	output sfr_rsp_t O_SFR_RSP,
	output route_t O_ROUTE,
	output sig_vec_t O_SIG_ROUTE_EN,
	output pin_sel_t O_PIN_SEL,
	output logic [`NPIN-1:0] O_PIN_FUNC
);
	logic [7:0] route_a_q;
	logic [7:0] route_b_q;
	logic hit_a;
	logic hit_b;
	sfr_rsp_t rsp_q;
	sfr_rsp_t rsp_d;
	pin_sel_t pin_sel_q;
	pin_sel_t pin_sel_d;
	logic [`NPIN-1:0] pin_func_q;
	logic [`NPIN-1:0] pin_func_d;
	sig_vec_t sig_en;
	sig_vec_t gated_en;
	logic [`CC_LINES-1:0] cc_mask;
	logic [2:0] cc_code;

	// Reserved codes route nothing rather than guess a line count
	function automatic logic [`CC_LINES-1:0] cc_lines(logic [2:0] code);
		logic [`CC_LINES-1:0] m;
		m = '0;
		for (int k = 0; k < `CC_LINES; k++) begin
			if (code <= `CC_MAX && k < int'(code)) begin
				m[k] = 1'b1;
			end
		end
		return m;
	endfunction

	sfr_route_reg #(
		.ADDR(`XBR_ADDR_A)
	) u_route_a (
		.i_clk(I_REF_CLK),
		.i_rst_b(I_RST_B),
		.i_req(I_SFR_REQ),
		.o_q(route_a_q),
		.o_hit(hit_a)
	);

	sfr_route_reg #(
		.ADDR(`XBR_ADDR_B)
	) u_route_b (
		.i_clk(I_REF_CLK),
		.i_rst_b(I_RST_B),
		.i_req(I_SFR_REQ),
		.o_q(route_b_q),
		.o_hit(hit_b)
	);

	// Field view of both registers
	assign O_ROUTE.cmp0 = route_a_q[`A_CMP0_BIT];
	assign O_ROUTE.eclk = route_a_q[`A_ECLK_BIT];
	assign O_ROUTE.cc_cnt = route_a_q[`A_CC_HI:`A_CC_LO];
	assign O_ROUTE.uart = route_a_q[`A_UART_BIT];
	assign O_ROUTE.spi = route_a_q[`A_SPI_BIT];
	assign O_ROUTE.smb = route_a_q[`A_SMB_BIT];
	assign O_ROUTE.sysck = route_b_q[`B_SYSCK_BIT];
	assign O_ROUTE.tmr2_capture_in = route_b_q[`B_TMR2_CAPTURE_IN_BIT];
	assign O_ROUTE.t2 = route_b_q[`B_T2_BIT];
	assign O_ROUTE.ext_irq_one_in = route_b_q[`B_EXT_IRQ_ONE_IN_BIT];
	assign O_ROUTE.t1 = route_b_q[`B_T1_BIT];
	assign O_ROUTE.ext_irq_zero_in = route_b_q[`B_EXT_IRQ_ZERO_IN_BIT];
	assign O_ROUTE.t0 = route_b_q[`B_T0_BIT];
	assign O_ROUTE.cmp1 = route_b_q[`B_CMP1_BIT];

	assign cc_code = route_a_q[`A_CC_HI:`A_CC_LO];
	assign cc_mask = cc_lines(cc_code);

	// Per-signal enables in priority order; buses expand to all their pins
	assign sig_en[`SIG_SMB+1:`SIG_SMB] = {2{route_a_q[`A_SMB_BIT]}};
	assign sig_en[`SIG_SPI+3:`SIG_SPI] = {4{route_a_q[`A_SPI_BIT]}};
	assign sig_en[`SIG_UART+1:`SIG_UART] = {2{route_a_q[`A_UART_BIT]}};
	assign sig_en[`SIG_CC+`CC_LINES-1:`SIG_CC] = cc_mask;
	assign sig_en[`SIG_ECI] = route_a_q[`A_ECLK_BIT];
	assign sig_en[`SIG_CP0] = route_a_q[`A_CMP0_BIT];
	assign sig_en[`SIG_CP1] = route_b_q[`B_CMP1_BIT];
	assign sig_en[`SIG_T0] = route_b_q[`B_T0_BIT];
	assign sig_en[`SIG_EXT_IRQ_ZERO_IN] = route_b_q[`B_EXT_IRQ_ZERO_IN_BIT];
	assign sig_en[`SIG_T1] = route_b_q[`B_T1_BIT];
	assign sig_en[`SIG_EXT_IRQ_ONE_IN] = route_b_q[`B_EXT_IRQ_ONE_IN_BIT];
	assign sig_en[`SIG_T2] = route_b_q[`B_T2_BIT];
	assign sig_en[`SIG_TMR2_CAPTURE_IN] = route_b_q[`B_TMR2_CAPTURE_IN_BIT];
	assign sig_en[`SIG_SYSCK] = route_b_q[`B_SYSCK_BIT];
	assign O_SIG_ROUTE_EN = sig_en;

	// Global enable gates the decoder, not the stored settings
	assign gated_en = I_XBAR_EN ? sig_en : '0;

	slot_decoder u_slots (
		.i_en(gated_en),
		.o_sel(pin_sel_d),
		.o_func(pin_func_d)
	);

	// Read path; other addresses belong to other registers and get no answer
	assign rsp_d.valid = I_SFR_REQ.rd && (hit_a || hit_b);
	assign rsp_d.rdata = !I_SFR_REQ.rd ? 8'h00 : hit_a ? route_a_q : hit_b ? route_b_q : 8'h00;

	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rsp_q <= '0;
			pin_sel_q <= '0;
			pin_func_q <= '0;
		end else begin
			rsp_q <= rsp_d;
			pin_sel_q <= pin_sel_d;
			pin_func_q <= pin_func_d;
		end
	end

	assign O_SFR_RSP = rsp_q;
	assign O_PIN_SEL = pin_sel_q;
	assign O_PIN_FUNC = pin_func_q;

	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RST_B);

	wire logic wr_a = I_SFR_REQ.wr && I_SFR_REQ.addr == `XBR_ADDR_A;
	wire logic wr_b = I_SFR_REQ.wr && I_SFR_REQ.addr == `XBR_ADDR_B;

	chk_write_a_lands: assert property (
		wr_a |=> route_a_q == $past(I_SFR_REQ.wdata)
	) else $error("route register A did not take the written byte");

	chk_write_b_lands: assert property (
		wr_b |=> route_b_q == $past(I_SFR_REQ.wdata)
	) else $error("route register B did not take the written byte");

	chk_a_holds: assert property (
		!wr_a |=> $stable(route_a_q)
	) else $error("route register A changed without a write");

	chk_read_back_a: assert property (
		I_SFR_REQ.rd && I_SFR_REQ.addr == `XBR_ADDR_A && !I_SFR_REQ.wr
		|=> O_SFR_RSP.valid && O_SFR_RSP.rdata == $past(route_a_q)
	) else $error("read of route register A returned wrong data");

	chk_read_back_b: assert property (
		I_SFR_REQ.rd && I_SFR_REQ.addr == `XBR_ADDR_B && !I_SFR_REQ.wr
		|=> O_SFR_RSP.valid && O_SFR_RSP.rdata == $past(route_b_q)
	) else $error("read of route register B returned wrong data");

	chk_unmapped_quiet: assert property (
		I_SFR_REQ.addr != `XBR_ADDR_A && I_SFR_REQ.addr != `XBR_ADDR_B
		|=> !O_SFR_RSP.valid && O_SFR_RSP.rdata == 8'h00
	) else $error("answer given for an address outside the block");

	chk_cmp0_follows: assert property (
		wr_a |=> O_SIG_ROUTE_EN[`SIG_CP0] == $past(I_SFR_REQ.wdata[`A_CMP0_BIT])
	) else $error("comparator-0 route does not follow its bit");

	chk_eclk_follows: assert property (
		wr_a |=> O_SIG_ROUTE_EN[`SIG_ECI] == $past(I_SFR_REQ.wdata[`A_ECLK_BIT])
	) else $error("external clock route does not follow its bit");

	chk_cc_count: assert property (
		wr_a |=> $countones(O_SIG_ROUTE_EN[`SIG_CC+4:`SIG_CC]) ==
			(($past(I_SFR_REQ.wdata[5:3]) <= 3'h5) ? $past(I_SFR_REQ.wdata[5:3]) : 0)
	) else $error("capture/compare line count wrong");

	chk_cc_low_first: assert property (
		((O_SIG_ROUTE_EN[`SIG_CC+4:`SIG_CC] + 1) & O_SIG_ROUTE_EN[`SIG_CC+4:`SIG_CC]) == 0
	) else $error("capture/compare lines not routed from line 0 up");

	chk_uart_pair: assert property (
		wr_a |=> O_SIG_ROUTE_EN[`SIG_UART+1:`SIG_UART] == {2{$past(I_SFR_REQ.wdata[`A_UART_BIT])}}
	) else $error("UART signals not routed as a pair");

	chk_spi_quad: assert property (
		wr_a |=> O_SIG_ROUTE_EN[`SIG_SPI+3:`SIG_SPI] == {4{$past(I_SFR_REQ.wdata[`A_SPI_BIT])}}
	) else $error("SPI signals not routed as a group of four");

	chk_smb_pins: assert property (
		I_XBAR_EN && O_ROUTE.smb |=>
			O_PIN_SEL[0] == `SEL_W'(`SIG_SMB + 1) && O_PIN_SEL[1] == `SEL_W'(`SIG_SMB + 2)
	) else $error("SMBus not on port 0 pins 0 and 1");

	chk_b_bits_follow: assert property (
		wr_b |=> O_SIG_ROUTE_EN[`SIG_SYSCK:`SIG_CP1] ==
			{$past(I_SFR_REQ.wdata[7]), $past(I_SFR_REQ.wdata[6]), $past(I_SFR_REQ.wdata[5]),
			$past(I_SFR_REQ.wdata[4]), $past(I_SFR_REQ.wdata[3]), $past(I_SFR_REQ.wdata[2]),
			$past(I_SFR_REQ.wdata[1]), $past(I_SFR_REQ.wdata[0])}
	) else $error("register B routes do not follow the written bits");

	chk_gate_off: assert property (
		!I_XBAR_EN |=> O_PIN_FUNC == '0 && O_PIN_SEL == '0
	) else $error("pin taken by a function while crossbar is disabled");

	chk_pin_count: assert property (
		##1 $countones(O_PIN_FUNC) == ($past(I_XBAR_EN) ? $countones($past(O_SIG_ROUTE_EN)) : 0)
	) else $error("pin map does not follow the enables one cycle later");

	chk_fill_low: assert property (
		((O_PIN_FUNC + 1) & O_PIN_FUNC) == 0
	) else $error("function pins are not packed from the lowest pin");

	chk_first_slot: assert property (
		I_XBAR_EN && O_SIG_ROUTE_EN != '0 |=> O_PIN_SEL[0] != '0
	) else $error("lowest pin left free with functions enabled");

	// Bus side: reset state, hold and answer shape; field views of the written bytes
	chk_b_holds: assert property (
		!wr_b |=> $stable(route_b_q)
	) else $error("route register B changed without a write");

	chk_reset_clear: assert property (
		$rose(I_RST_B) |-> route_a_q == `XBR_RST && route_b_q == `XBR_RST &&
			O_PIN_FUNC == '0 && !O_SFR_RSP.valid
	) else $error("state not cleared at reset release");

	chk_valid_after_read: assert property (
		O_SFR_RSP.valid |-> $past(I_SFR_REQ.rd)
	) else $error("read answer without a read request");

	chk_no_read_quiet: assert property (
		!I_SFR_REQ.rd |=> O_SFR_RSP.rdata == 8'h00
	) else $error("read data driven without a read");

	chk_view_a: assert property (
		wr_a |=> {O_ROUTE.cmp0, O_ROUTE.eclk, O_ROUTE.cc_cnt, O_ROUTE.uart, O_ROUTE.spi, O_ROUTE.smb} ==
			$past(I_SFR_REQ.wdata)
	) else $error("field view of register A differs from the written byte");

	chk_view_b: assert property (
		wr_b |=> {O_ROUTE.sysck, O_ROUTE.tmr2_capture_in, O_ROUTE.t2, O_ROUTE.ext_irq_one_in, O_ROUTE.t1, O_ROUTE.ext_irq_zero_in, O_ROUTE.t0,
			O_ROUTE.cmp1} == $past(I_SFR_REQ.wdata)
	) else $error("field view of register B differs from the written byte");

	// Reserved codes must not leak a partial line count
	chk_cc_reserved: assert property (
		O_ROUTE.cc_cnt > `CC_MAX |-> O_SIG_ROUTE_EN[`SIG_CC+4:`SIG_CC] == '0
	) else $error("reserved capture/compare code routed lines");

	// Pin order: each check places a signal after the enabled ones ahead of it
	chk_spi_after_smb: assert property (
		I_XBAR_EN && O_ROUTE.smb && O_ROUTE.spi |=>
			O_PIN_SEL[2] == `SEL_W'(`SIG_SPI + 1) && O_PIN_SEL[5] == `SEL_W'(`SIG_SPI + 4)
	) else $error("SPI group not placed right after SMBus");

	chk_smb_skipped: assert property (
		I_XBAR_EN && !O_ROUTE.smb && O_ROUTE.spi |=> O_PIN_SEL[0] == `SEL_W'(`SIG_SPI + 1)
	) else $error("SPI did not move up when SMBus is off");

	chk_uart_skips: assert property (
		I_XBAR_EN && O_ROUTE.uart && !O_ROUTE.smb && !O_ROUTE.spi |=>
			O_PIN_SEL[0] == `SEL_W'(`SIG_UART + 1) && O_PIN_SEL[1] == `SEL_W'(`SIG_UART + 2)
	) else $error("UART pair not on the lowest pins");

	chk_cc_first: assert property (
		I_XBAR_EN && O_ROUTE.cc_cnt != 3'h0 && O_ROUTE.cc_cnt <= `CC_MAX &&
			!O_ROUTE.smb && !O_ROUTE.spi && !O_ROUTE.uart |=> O_PIN_SEL[0] == `SEL_W'(`SIG_CC + 1)
	) else $error("capture/compare line 0 not on the lowest pin");

	chk_sysck_last: assert property (
		I_XBAR_EN && O_ROUTE.sysck |=>
			O_PIN_SEL[$countones($past(O_SIG_ROUTE_EN)) - 1] == `SEL_W'(`SIG_SYSCK + 1)
	) else $error("system clock output not on the last function pin");

	// At most 23 signals, so the top pin always stays a port pin
	chk_top_pin_free: assert property (
		!O_PIN_FUNC[`NPIN-1]
	) else $error("top pin taken by a function");

	chk_gate_rise: assert property (
		$rose(I_XBAR_EN) |=> O_PIN_FUNC[0] == (|$past(O_SIG_ROUTE_EN))
	) else $error("pin map did not follow the global enable");
endmodule

// ### tb/xbar_enable_model.sv
/*
 Holder of the global crossbar enable, standing where the third crossbar
 register would sit. Assumes writes come as one-cycle strobes from the bench.
*/
`timescale 1ns/1ps
module xbar_enable_model (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_we,
	input wire logic i_val,
	output logic o_en
);
	logic en_q;
	// Off out of reset so every pin starts as a plain input
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			en_q <= 1'b0;
		end else if (i_we) begin
			en_q <= i_val;
		end
	end
	assign o_en = en_q;
endmodule

// ### tb/crossbar_route_enable_regs_tb_top.sv
/*
 Self-checking bench of the crossbar route-enable registers.
 Assumes the enable model above drives the global crossbar enable.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin bad_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module crossbar_route_enable_regs_tb_top import crossbar_pkg::*;;
	logic clk = 1'b0;
	logic rst_b;
	logic en_we;
	logic en_val;
	logic xbar_en;
	sfr_req_t req;
	sfr_rsp_t rsp;
	route_t route;
	sig_vec_t sig_en;
	pin_sel_t pin_sel;
	logic [23:0] pin_func;
	logic [7:0] ra, rb, q[$];
	logic [7:0] exp_rd;
	logic en_s;
	logic [31:0] seed;
	int bad_count = 0;
	int comparisons = 0;
	always #2.5 clk = ~clk;
	xbar_enable_model u_en (.i_clk(clk), .i_rst_b(rst_b), .i_we(en_we), .i_val(en_val), .o_en(xbar_en));
	crossbar_route_enable_regs dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_SFR_REQ(req), .I_XBAR_EN(xbar_en),
		.O_SFR_RSP(rsp), .O_ROUTE(route), .O_SIG_ROUTE_EN(sig_en), .O_PIN_SEL(pin_sel), .O_PIN_FUNC(pin_func));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic sig_vec_t ref_vec(logic [7:0] a, logic [7:0] b);
		sig_vec_t v;
		v = '0;
		v[1:0] = {2{a[0]}};
		v[5:2] = {4{a[1]}};
		v[7:6] = {2{a[2]}};
		// Reserved codes 6 and 7 route no lines
		for (int i = 0; i < 5; i++) v[8+i] = (a[5:3] <= 3'h5) && (i < a[5:3]);
		v[14:13] = a[7:6];
		v[22:15] = b;
		return v;
	endfunction
	function automatic pin_sel_t ref_sel(sig_vec_t v, logic en);
		pin_sel_t s;
		int k;
		s = '0;
		k = 0;
		for (int i = 0; i < 23; i++) if (en && v[i]) begin
			s[k] = 5'(i + 1);
			k++;
		end
		return s;
	endfunction
	task automatic xfer(logic w, logic [7:0] ad, logic [7:0] d);
		@(posedge clk);
		#1;
		req = '{wr: w, rd: !w, addr: ad, wdata: d};
		if (!w && (ad == 8'hE1)) q.push_back(ra);
		if (!w && (ad == 8'hE2)) q.push_back(rb);
		if (w && (ad == 8'hE1)) ra = d;
		if (w && (ad == 8'hE2)) rb = d;
		@(posedge clk);
		#1;
		req = '0;
	endtask
	task automatic set_en(logic v);
		@(posedge clk);
		#1;
		en_we = 1'b1;
		en_val = v;
		en_s = v;
		@(posedge clk);
		#1;
		en_we = 1'b0;
	endtask
	task automatic check_map();
		pin_sel_t s;
		logic [23:0] f;
		repeat (3) @(posedge clk);
		#1;
		s = ref_sel(ref_vec(ra, rb), en_s);
		for (int j = 0; j < 24; j++) f[j] = (s[j] != 5'h00);
		`CHK("route", route_t'({ra, rb}), route)
		`CHK("sig_en", ref_vec(ra, rb), sig_en)
		`CHK("pin_sel", s, pin_sel)
		`CHK("pin_func", f, pin_func)
	endtask
	// Mid-cycle look, away from the edge that launches the answer
	always @(negedge clk) begin
		if (rsp.valid === 1'b1) begin
			if (q.size() == 0) begin
				bad_count++;
				$display("[ERR] rsp exp none got %0h", rsp.rdata);
			end else begin
				exp_rd = q.pop_front();
				`CHK("rdata", exp_rd, rsp.rdata)
			end
		end
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		complete_run();
	end
	initial begin
		req = '0;
		en_we = 1'b0;
		en_val = 1'b0;
		en_s = 1'b0;
		ra = 8'h00;
		rb = 8'h00;
		seed = 32'd52790;
		rst_b = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rst_b = 1'b1;
		xfer(1'b0, 8'hE1, 8'h00);
		xfer(1'b0, 8'hE2, 8'h00);
		check_map();
		$display("test reset done");
		set_en(1'b1);
		for (int c = 0; c < 8; c++) begin
			xfer(1'b1, 8'hE1, {rnd() & 8'hC7} | 8'(c << 3));
			xfer(1'b1, 8'hE2, rnd());
			xfer(1'b0, 8'hE1, 8'h00);
			check_map();
		end
		$display("test capcomp done");
		for (int n = 0; n < 24; n++) begin
			xfer(1'b1, 8'hE1, rnd());
			xfer(1'b1, 8'hE2, rnd());
			if (n % 6 == 5) set_en(!en_s);
			xfer(1'b0, 8'hE2, 8'h00);
			check_map();
		end
		$display("test random done");
		xfer(1'b1, 8'hE3, 8'hFF);
		xfer(1'b1, 8'hE0, 8'hFF);
		xfer(1'b0, 8'hE3, 8'h00);
		xfer(1'b0, 8'hE1, 8'h00);
		check_map();
		$display("test unmapped done");
		@(posedge clk);
		#1;
		rst_b = 1'b0;
		ra = 8'h00;
		rb = 8'h00;
		en_s = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_b = 1'b1;
		check_map();
		xfer(1'b0, 8'hE2, 8'h00);
		repeat (3) @(posedge clk);
		`CHK("pending", 0, q.size())
		$display("test midreset done");
		complete_run();
	end
endmodule
